/* File: hw/imt_decode_cfg.svh */
// Constants for the instruction mode and timing decoder.
// Function
// (RULE_01) One opcode for both indirect, both indexed forms
// (RULE_02) Second byte bit zero selects the mode
// (RULE_03) Word register address from upper seven bits
// (RULE_04) Short call/jump: eleven-bit signed offset
// (RULE_05) Byte decrement, bit branches: 5 or 9
// (RULE_06) Word decrement branch: 6 or 10
// (RULE_07) Flag conditional branches: 4 or 8
// (RULE_08) Register operands use shorter counts
// (RULE_09) Memory operands use longer counts
// (RULE_10) Prefix byte marks signed multiply/divide
// (RULE_11) Hold issue until state count elapses
`ifndef IMT_DECODE_CFG_SVH
`define IMT_DECODE_CFG_SVH
`define IMT_OP_PREFIX 8'hfe
`define IMT_OP_BDJNZ 8'he0
`define IMT_OP_WDJNZ 8'he1
`define IMT_OP_BITBR_HI 4'h3
`define IMT_OP_FLAGBR_HI 4'hd
`define IMT_OP_SHORT_RELATIVE_JUMP_HI 5'h04
`define IMT_OP_SHORT_RELATIVE_CALL_HI 5'h05
`define IMT_MODE_BIT 0
`define IMT_T_BYTE_NT 5'd5
`define IMT_T_BYTE_TK 5'd9
`define IMT_T_WORD_NT 5'd6
`define IMT_T_WORD_TK 5'd10
`define IMT_T_FLAG_NT 5'd4
`define IMT_T_FLAG_TK 5'd8
`define IMT_T_IND_REG 5'd6
`define IMT_T_IND_MEM 5'd8
`define IMT_T_AUTO_EXTRA 5'd1
`define IMT_T_THREE_OP_EXTRA 5'd1
`define IMT_T_THREE_OP_MEM_EXTRA 5'd2
`define IMT_T_DEFAULT 5'd4
`endif

/* File: hw/imt_decode_pkg.sv */
// Types for the instruction mode and timing decoder.
package imt_decode_pkg;
	typedef enum logic [2:0] {
		IMT_MODE_OTHER,
		IMT_MODE_IND_NORMAL,
		IMT_MODE_IND_AUTOINC,
		IMT_MODE_IDX_SHORT,
		IMT_MODE_IDX_LONG
	} imt_mode_t;
	typedef enum logic [2:0] {
		IMT_CLS_OTHER,
		IMT_CLS_BYTE_DEC,
		IMT_CLS_WORD_DEC,
		IMT_CLS_BIT_BR,
		IMT_CLS_FLAG_BR,
		IMT_CLS_SHORT_REL,
		IMT_CLS_ALU
	} imt_class_t;
	typedef enum logic [1:0] {
		IMT_ST_IDLE,
		IMT_ST_PREFIX,
		IMT_ST_RUN
	} imt_state_t;
endpackage : imt_decode_pkg

/* File: hw/imt_state_timer.sv */
// Down counter that holds issue for a loaded number of state times.
`timescale 1ns/1ps
`include "imt_decode_cfg.svh"
module imt_state_timer #(
	parameter int CW = 5
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic load,
	input wire logic [CW-1:0] count,
	output logic busy
);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic busy_q;
	logic busy_d;

	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		// (RULE_11) load and count
		if (load) begin
			cnt_d = count - CW'(1);
			busy_d = (count > CW'(1));
		end else if (busy_q) begin
			cnt_d = cnt_q - CW'(1);
			busy_d = (cnt_q > CW'(1));
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
		end
	end

	assign busy = busy_q;
endmodule : imt_state_timer

/* File: hw/imt_decode.sv */
// Addressing mode, relative offset and state-time decoder.
`timescale 1ns/1ps
`include "imt_decode_cfg.svh"
module imt_decode
	import imt_decode_pkg::*;
#(
	parameter int CW = 5
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic insnValid,
	input wire logic [7:0] opByte,
	input wire logic [7:0] secondByte,
	input wire logic branchTaken,
	input wire logic operandInMem,
	output logic insnReady,
	output logic issueValid,
	output logic signedOp,
	output imt_mode_t addrMode,
	output logic [7:0] wordRegAddr,
	output logic [10:0] relOffset,
	output logic [CW-1:0] stateTimes,
	output logic busy
);
	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic imt_class_t classify(input logic [7:0] op);
		imt_class_t c;
		c = IMT_CLS_OTHER;
		if (op == `IMT_OP_BDJNZ) begin
			c = IMT_CLS_BYTE_DEC;
		end else if (op == `IMT_OP_WDJNZ) begin
			c = IMT_CLS_WORD_DEC;
		end else if (op[7:4] == `IMT_OP_BITBR_HI) begin
			c = IMT_CLS_BIT_BR;
		end else if (op[7:4] == `IMT_OP_FLAGBR_HI) begin
			c = IMT_CLS_FLAG_BR;
		end else if (op[7:3] == `IMT_OP_SHORT_RELATIVE_JUMP_HI ||
			op[7:3] == `IMT_OP_SHORT_RELATIVE_CALL_HI) begin
			c = IMT_CLS_SHORT_REL;
		end else if (op[7:6] == 2'b01 || op[7:6] == 2'b10) begin
			c = IMT_CLS_ALU;
		end
		return c;
	endfunction : classify

	// Low two opcode bits 10 and 11 pick indirect and indexed; other values give IMT_MODE_OTHER.
	function automatic imt_mode_t pick_mode(input logic [7:0] op,
		input logic b0);
		imt_mode_t m;
		m = IMT_MODE_OTHER;
		// (RULE_01) shared opcode forms
		if (op[1:0] == 2'b10) begin
			// (RULE_02) bit zero selects
			m = b0 ? IMT_MODE_IND_AUTOINC : IMT_MODE_IND_NORMAL;
		end else if (op[1:0] == 2'b11) begin
			m = b0 ? IMT_MODE_IDX_LONG : IMT_MODE_IDX_SHORT;
		end
		return m;
	endfunction : pick_mode

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	imt_state_t state_q;
	imt_state_t state_d;
	logic signed_q;
	logic signed_d;
	logic issue_q;
	logic issue_d;
	logic signedOut_q;
	logic signedOut_d;
	imt_mode_t mode_q;
	imt_mode_t mode_d;
	logic [7:0] wreg_q;
	logic [7:0] wreg_d;
	logic [10:0] rel_q;
	logic [10:0] rel_d;
	logic [CW-1:0] st_q;
	logic [CW-1:0] st_d;
	logic ready_q;
	logic ready_d;
	logic busy_q;
	logic busy_d;
	logic timerLoad;
	logic timerBusy;
	imt_class_t cls;
	imt_mode_t modeNow;
	logic [CW-1:0] timeNow;

	always_comb begin
		cls = classify(opByte);
		modeNow = IMT_MODE_OTHER;
		// Branches carry a displacement, not a register byte, so no mode.
		if (cls == IMT_CLS_ALU) begin
			modeNow = pick_mode(opByte, secondByte[`IMT_MODE_BIT]);
		end
		timeNow = `IMT_T_DEFAULT;
		case (cls)
			IMT_CLS_BYTE_DEC, IMT_CLS_BIT_BR: begin
				// (RULE_05) five or nine
				timeNow = branchTaken ? `IMT_T_BYTE_TK : `IMT_T_BYTE_NT;
			end
			IMT_CLS_WORD_DEC: begin
				// (RULE_06) six or ten
				timeNow = branchTaken ? `IMT_T_WORD_TK : `IMT_T_WORD_NT;
			end
			IMT_CLS_FLAG_BR: begin
				// (RULE_07) four or eight
				timeNow = branchTaken ? `IMT_T_FLAG_TK : `IMT_T_FLAG_NT;
			end
			IMT_CLS_ALU: begin
				if (modeNow != IMT_MODE_OTHER) begin
					// (RULE_08) register column
					timeNow = `IMT_T_IND_REG;
					// (RULE_09) memory column
					if (operandInMem) begin
						timeNow = `IMT_T_IND_MEM;
					end
					if (modeNow == IMT_MODE_IND_AUTOINC ||
						modeNow == IMT_MODE_IDX_LONG) begin
						timeNow = timeNow + `IMT_T_AUTO_EXTRA;
					end
					// Three-operand forms sit at opcodes 4x/5x.
					if (opByte[7:5] == 3'b010) begin
						timeNow = timeNow + (operandInMem ?
							`IMT_T_THREE_OP_MEM_EXTRA :
							`IMT_T_THREE_OP_EXTRA);
					end
				end
			end
			default: begin
				timeNow = `IMT_T_DEFAULT;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Issue control
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		signed_d = signed_q;
		issue_d = 1'b0;
		signedOut_d = signedOut_q;
		mode_d = mode_q;
		wreg_d = wreg_q;
		rel_d = rel_q;
		st_d = st_q;
		timerLoad = 1'b0;
		ready_d = 1'b0;
		case (state_q)
			IMT_ST_IDLE, IMT_ST_PREFIX: begin
				// (RULE_11) hold while counting
				ready_d = !timerBusy && !busy_q;
				if (insnValid && ready_q) begin
					// (RULE_10) signed prefix byte
					if (opByte == `IMT_OP_PREFIX &&
						state_q == IMT_ST_IDLE) begin
						state_d = IMT_ST_PREFIX;
						signed_d = 1'b1;
						ready_d = 1'b1;
					end else begin
						timerLoad = 1'b1;
						issue_d = 1'b1;
						signedOut_d = signed_q;
						signed_d = 1'b0;
						mode_d = modeNow;
						// (RULE_03) even word address
						wreg_d = {secondByte[7:1], 1'b0};
						// (RULE_04) eleven-bit offset
						rel_d = {opByte[2:0], secondByte};
						st_d = timeNow;
						state_d = IMT_ST_RUN;
						ready_d = 1'b0;
					end
				end
			end
			IMT_ST_RUN: begin
				if (!timerBusy) begin
					state_d = IMT_ST_IDLE;
					ready_d = 1'b1;
				end
			end
			default: begin
				state_d = IMT_ST_IDLE;
			end
		endcase
		busy_d = timerBusy || timerLoad;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= IMT_ST_IDLE;
			signed_q <= 1'b0;
			issue_q <= 1'b0;
			signedOut_q <= 1'b0;
			mode_q <= IMT_MODE_OTHER;
			wreg_q <= 8'h00;
			rel_q <= 11'h000;
			st_q <= '0;
			ready_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			signed_q <= signed_d;
			issue_q <= issue_d;
			signedOut_q <= signedOut_d;
			mode_q <= mode_d;
			wreg_q <= wreg_d;
			rel_q <= rel_d;
			st_q <= st_d;
			ready_q <= ready_d;
			busy_q <= busy_d;
		end
	end

	// ------------------------------------------------------------
	// State-time counter
	// ------------------------------------------------------------
	imt_state_timer #(
		.CW(CW)
	) u_timer (
		.mclk(mclk),
		.rst(rst),
		.load(timerLoad),
		.count(timeNow),
		.busy(timerBusy)
	);

	assign insnReady = ready_q;
	assign issueValid = issue_q;
	assign signedOp = signedOut_q;
	assign addrMode = mode_q;
	assign wordRegAddr = wreg_q;
	assign relOffset = rel_q;
	assign stateTimes = st_q;
	assign busy = busy_q;
endmodule : imt_decode

/* File: bench/imt_decode_assertions.sv */
// Concurrent checks on the decoder's ports.
`timescale 1ns/1ps
module imt_decode_assertions
	import imt_decode_pkg::*;
#(
	parameter int CW = 5
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic insnValid,
	input wire logic [7:0] opByte,
	input wire logic [7:0] secondByte,
	input wire logic branchTaken,
	input wire logic operandInMem,
	input wire logic insnReady,
	input wire logic issueValid,
	input wire logic signedOp,
	input wire imt_mode_t addrMode,
	input wire logic [7:0] wordRegAddr,
	input wire logic [10:0] relOffset,
	input wire logic [CW-1:0] stateTimes,
	input wire logic busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Busy cycles since the last issue, compared with the loaded count.
	logic [5:0] cnt_q, cnt_d;
	always_comb begin
		cnt_d = cnt_q;
		if (issueValid) cnt_d = 6'h01;
		else if (busy) cnt_d = cnt_q + 6'h01;
	end
	always_ff @(posedge mclk) begin
		if (rst) cnt_q <= 6'h00;
		else cnt_q <= cnt_d;
	end
	AST_WREG: assert property (
		issueValid |-> wordRegAddr == {$past(secondByte[7:1]), 1'b0})
		else $error("word register address wrong");
	AST_REL: assert property (
		issueValid && $past(opByte[7:4]) == 4'h2 |->
		relOffset == {$past(opByte[2:0]), $past(secondByte)})
		else $error("relative offset wrong");
	AST_IND: assert property (
		issueValid && $past(opByte[1:0]) == 2'b10 &&
		$past(opByte[7:6]) inside {2'b01, 2'b10} |-> addrMode ==
		($past(secondByte[0]) ? IMT_MODE_IND_AUTOINC : IMT_MODE_IND_NORMAL))
		else $error("indirect mode wrong");
	AST_FLAG: assert property (
		issueValid && $past(opByte[7:4]) == 4'hd |->
		stateTimes == CW'($past(branchTaken) ? 8 : 4))
		else $error("flag branch time wrong");
	AST_BDEC: assert property (
		issueValid && ($past(opByte) == 8'he0 || $past(opByte[7:4]) == 4'h3)
		|-> stateTimes == CW'($past(branchTaken) ? 9 : 5))
		else $error("byte branch time wrong");
	AST_WDEC: assert property (
		issueValid && $past(opByte) == 8'he1 |->
		stateTimes == CW'($past(branchTaken) ? 10 : 6))
		else $error("word branch time wrong");
	AST_OPND: assert property (
		issueValid && $past(opByte) == 8'h66 && !$past(secondByte[0]) |->
		stateTimes == CW'($past(operandInMem) ? 8 : 6))
		else $error("operand place time wrong");
	AST_HOLD: assert property (
		busy |-> !insnReady)
		else $error("ready while busy");
	AST_BUSYLEN: assert property (
		$fell(busy) |-> cnt_q == 6'(stateTimes) && insnReady)
		else $error("busy length wrong");
	cover property (issueValid && signedOp);
	cover property (issueValid && addrMode == IMT_MODE_IDX_LONG);
	cover property ($fell(busy) && cnt_q == 6'h0a);
endmodule : imt_decode_assertions

/* File: bench/tb_top.sv */
// Self-checking bench for the instruction mode and timing decoder.
`timescale 1ns/1ps
module tb_top;
	import imt_decode_pkg::*;
	logic mclk, rst, insnValid, branchTaken, operandInMem;
	logic insnReady, issueValid, signedOp, busy;
	logic [7:0] opByte, secondByte, wordRegAddr;
	logic [10:0] relOffset;
	logic [4:0] stateTimes;
	imt_mode_t addrMode;
	int err_total, checks_done;
	imt_decode #(.CW(5)) u_imt_decode(.mclk(mclk), .rst(rst),
		.insnValid(insnValid), .opByte(opByte), .secondByte(secondByte),
		.branchTaken(branchTaken), .operandInMem(operandInMem),
		.insnReady(insnReady), .issueValid(issueValid), .signedOp(signedOp),
		.addrMode(addrMode), .wordRegAddr(wordRegAddr),
		.relOffset(relOffset), .stateTimes(stateTimes), .busy(busy));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic chk(input string what, input logic [10:0] e, g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic send(input logic [7:0] op, sb, input logic tk, mem);
		@(posedge mclk) #1;
		for (int k = 0; insnReady !== 1'b1; k++) begin
			if (k > 40) err_total++;
			if (k > 40) tally_and_finish();
			@(posedge mclk) #1;
		end
		{opByte, secondByte, branchTaken, operandInMem} = {op, sb, tk, mem};
		insnValid = 1'b1;
		@(posedge mclk) #1;
		insnValid = 1'b0;
	endtask : send
	// A held request while not ready must be ignored.
	task automatic issue(input logic [7:0] op, sb, input logic tk, mem,
		input int n, input imt_mode_t md, input logic s);
		int k;
		send(op, sb, tk, mem);
		chk("issueValid", 1, issueValid);
		chk("stateTimes", n, stateTimes);
		chk("addrMode", md, addrMode);
		chk("wordRegAddr", {sb[7:1], 1'b0}, wordRegAddr);
		chk("signedOp", s, signedOp);
		if (op[7:4] == 4'h2) begin
			chk("relOffset", {op[2:0], sb}, relOffset);
		end
		opByte = 8'hd0;
		@(posedge mclk) #1;
		insnValid = 1'b1;
		chk("noIssue", 0, issueValid);
		for (k = 1; k < 40 && insnReady !== 1'b1; k++) begin
			@(posedge mclk) #1;
			chk("noIssue", 0, issueValid);
		end
		insnValid = 1'b0;
		chk("holdLen", n, k);
		chk("busy", 0, busy);
	endtask : issue
	task automatic t_flag();
		for (int c = 0; c < 32; c++) begin
			issue({4'hd, c[3:0]}, 8'h05, c[4], 0, c[4] ? 8 : 4,
				IMT_MODE_OTHER, 0);
		end
	endtask : t_flag
	task automatic t_dec();
		issue(8'he0, 8'h10, 0, 0, 5, IMT_MODE_OTHER, 0);
		issue(8'he0, 8'h10, 1, 0, 9, IMT_MODE_OTHER, 0);
		issue(8'h30, 8'h20, 1, 0, 9, IMT_MODE_OTHER, 0);
		issue(8'h3f, 8'h20, 0, 0, 5, IMT_MODE_OTHER, 0);
		issue(8'he1, 8'h12, 0, 0, 6, IMT_MODE_OTHER, 0);
		issue(8'he1, 8'h12, 1, 0, 10, IMT_MODE_OTHER, 0);
	endtask : t_dec
	task automatic t_modes();
		issue(8'h66, 8'h22, 0, 0, 6, IMT_MODE_IND_NORMAL, 0);
		issue(8'h66, 8'h22, 0, 1, 8, IMT_MODE_IND_NORMAL, 0);
		issue(8'h66, 8'hff, 0, 1, 9, IMT_MODE_IND_AUTOINC, 0);
		issue(8'h67, 8'h44, 0, 1, 8, IMT_MODE_IDX_SHORT, 0);
		issue(8'h67, 8'h45, 0, 0, 7, IMT_MODE_IDX_LONG, 0);
		issue(8'h46, 8'h22, 0, 1, 10, IMT_MODE_IND_NORMAL, 0);
		issue(8'h8a, 8'h81, 0, 0, 7, IMT_MODE_IND_AUTOINC, 0);
	endtask : t_modes
	task automatic t_rel();
		issue(8'h20, 8'h00, 0, 0, 4, IMT_MODE_OTHER, 0);
		issue(8'h27, 8'hff, 0, 0, 4, IMT_MODE_OTHER, 0);
		issue(8'h2c, 8'h80, 0, 0, 4, IMT_MODE_OTHER, 0);
	endtask : t_rel
	task automatic t_signed();
		send(8'hfe, 8'h00, 0, 0);
		chk("prefixQuiet", 0, issueValid);
		issue(8'h6e, 8'h31, 0, 1, 9, IMT_MODE_IND_AUTOINC, 1);
		issue(8'h6e, 8'h30, 0, 0, 6, IMT_MODE_IND_NORMAL, 0);
	endtask : t_signed
	initial begin
		{rst, insnValid, branchTaken, operandInMem} = 4'b1000;
		{opByte, secondByte} = 16'h0000;
		repeat (8) @(posedge mclk);
		#1 rst = 1'b0;
		chk("rstBusy", 0, busy);
		chk("rstReady", 0, insnReady);
		t_flag();
		t_dec();
		t_modes();
		t_rel();
		t_signed();
		tally_and_finish();
	end
endmodule : tb_top
bind imt_decode imt_decode_assertions #(.CW(CW)) u_imt_decode_assertions(
	.mclk(mclk), .rst(rst), .insnValid(insnValid), .opByte(opByte),
	.secondByte(secondByte), .branchTaken(branchTaken),
	.operandInMem(operandInMem), .insnReady(insnReady),
	.issueValid(issueValid), .signedOp(signedOp), .addrMode(addrMode),
	.wordRegAddr(wordRegAddr), .relOffset(relOffset),
	.stateTimes(stateTimes), .busy(busy));
